// *** include/mem_mode_pkg.sv ***
// constants for the memory map and operating-mode control block
package mem_mode_pkg;

    // ------------------------------------------------------------------
    // address map of bank 0
    // ------------------------------------------------------------------
    localparam logic [23:0] sfr_base      = 24'h000000;
    localparam logic [23:0] sfr_last      = 24'h00007f;
    localparam logic [23:0] ram_base      = 24'h000080;
    localparam logic [23:0] ram_last      = 24'h00027f;
    localparam int          ram_bytes     = 512;
    localparam int          ram_aw        = 9;
    localparam logic [23:0] rom_base      = 24'h00c000;
    localparam logic [23:0] rom_last      = 24'h00ffff;
    localparam int          rom_bytes     = 16384;
    localparam int          rom_aw        = 14;
    localparam logic [23:0] vec_base      = 24'h00ffd6;
    localparam logic [23:0] vec_last      = 24'h00ffff;

    // ------------------------------------------------------------------
    // operating-mode control register
    // ------------------------------------------------------------------
    localparam logic [23:0] mode_ctrl_addr = 24'h00005e;
    localparam int          mode_lo_bit    = 0;
    localparam int          mode_hi_bit    = 1;
    localparam int          wait_bit       = 2;
    localparam int          swrst_bit      = 3;
    localparam logic [7:0]  mode_ctrl_rst  = 8'h00;

    // mode field encodings
    typedef enum logic [1:0] {
        mode_single   = 2'b00,
        mode_expand   = 2'b01,
        mode_micro    = 2'b10,
        mode_reserved = 2'b11
    } op_mode_t;

    // external access sequencer, gray along idle-strobe-wait-release
    typedef enum logic [1:0] {
        ext_idle    = 2'b00,
        ext_strobe  = 2'b01,
        ext_wait    = 2'b11,
        ext_release = 2'b10
    } ext_state_t;

    // software reset pulse length in cycles
    localparam logic [3:0]  swrst_cycles   = 4'h8;

endpackage : mem_mode_pkg

// *** hdl/range_decoder.sv ***
// inclusive address range comparator
module range_decoder
    import mem_mode_pkg::*;
#(
    parameter logic [23:0] lo = 24'h000000,
    parameter logic [23:0] hi = 24'h000000
) (
    // address in
    input  wire logic [23:0] addr,
    // hit out
    output logic             hit
);

    // ------------------------------------------------------------------
    // compare
    // ------------------------------------------------------------------
    // bank byte included, so only bank 0 hits
    assign hit = (addr >= lo) && (addr <= hi);

endmodule // range_decoder

// *** hdl/mem_mode_ctrl.sv ***
// memory map decode and operating-mode control for bank 0
// Notes on behaviour
// - writes to read-only bits ignored; write-only bits read zero
// - internal 512-byte RAM decoded at 0x0080 to 0x027f, bank 0
// - internal 16K-byte ROM decoded at 0xc000 to 0xffff, bank 0
// - 0xffd6 to 0xffff is the reset and interrupt vector table
// - mode pin low at reset release: start single-chip, any mode later
// - mode pin high at reset release: start in microprocessor mode
// - from single-chip start, mode bits 1:0 change the mode
// - new mode reaches pins when the write strobe returns high
// - single-chip mode drives no external address or data bus
// - single-chip ignores the wait bit; internal reads never wait, overlapping writes wait in expansion modes
// - mode codes: 00 single, 01 expansion, 10 micro, 11 invalid
// - wait bit 0 adds an external wait, 1 means no wait
// - writing one to the software reset bit resets the device
// - wait bit clears on reset, external accesses start with a wait
// - overlap reads return internal data, writes go to both
module mem_mode_ctrl
    import mem_mode_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // mode-select pin, asynchronous
    input  wire logic        mode_select_pin,
    // internal bus from the cpu
    input  wire logic [23:0] bus_addr,
    input  wire logic        bus_strobe_n,
    input  wire logic        bus_rd_wr_n,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             bus_ready,
    // internal rom image port
    output logic      [13:0] rom_addr,
    input  wire logic [7:0]  rom_data,
    // expansion bus
    output logic      [23:0] ext_addr,
    output logic      [7:0]  ext_wdata,
    output logic             ext_data_oe,
    input  wire logic [7:0]  ext_rdata,
    output logic             ext_strobe_n,
    output logic             ext_rd_wr_n,
    output logic             ext_bus_en,
    // decode and status
    output logic             sel_sfr,
    output logic             sel_ram,
    output logic             sel_rom,
    output logic             sel_vector,
    output logic      [1:0]  active_mode,
    output logic             sw_reset_req
);

    // ------------------------------------------------------------------
    // pin synchroniser and strap capture
    // ------------------------------------------------------------------
    logic       pin_meta;
    logic       pin_sync;
    logic       strap_done;

    // two flops before any logic reads the pin; kept out of reset so the
    // strap has already settled when reset is released
    always_ff @(posedge clk) begin
        if (clk_en) begin
            pin_meta <= mode_select_pin;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic hit_sfr;
    logic hit_ram;
    logic hit_rom;
    logic hit_vec;
    logic hit_mode_reg;

    range_decoder #(.lo(sfr_base), .hi(sfr_last)) u_dec_sfr (
        .addr (bus_addr),
        .hit  (hit_sfr)
    );
    range_decoder #(.lo(ram_base), .hi(ram_last)) u_dec_ram (
        .addr (bus_addr),
        .hit  (hit_ram)
    );
    range_decoder #(.lo(rom_base), .hi(rom_last)) u_dec_rom (
        .addr (bus_addr),
        .hit  (hit_rom)
    );
    range_decoder #(.lo(vec_base), .hi(vec_last)) u_dec_vec (
        .addr (bus_addr),
        .hit  (hit_vec)
    );

    assign hit_mode_reg = (bus_addr == mode_ctrl_addr);

    // ------------------------------------------------------------------
    // mode control register state
    // ------------------------------------------------------------------
    op_mode_t   cur_mode;
    op_mode_t   pend_mode;
    logic       pend_valid;
    logic       wait_en_n;
    logic       strobe_q;
    logic       wr_mode;
    logic       strobe_rise;
    logic [3:0] swrst_cnt;

    assign wr_mode     = !bus_strobe_n && !bus_rd_wr_n && hit_mode_reg;
    assign strobe_rise = bus_strobe_n && !strobe_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b1;
        end else if (clk_en) begin
            strobe_q <= bus_strobe_n;
        end
    end

    // strap caught on the first enabled edge after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done <= 1'b0;
        end else if (clk_en && !strap_done) begin
            strap_done <= 1'b1;
        end
    end

    // pending mode latched during the write strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_mode  <= mode_single;
            pend_valid <= 1'b0;
        end else if (clk_en) begin
            if (wr_mode &&
                op_mode_t'(bus_wdata[mode_hi_bit:mode_lo_bit])
                    != mode_reserved) begin
                pend_mode  <= op_mode_t'(bus_wdata[mode_hi_bit:mode_lo_bit]);
                pend_valid <= 1'b1;
            end else if (strobe_rise) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // after the strap capture, active mode moves only when the strobe goes back high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_mode <= mode_single;
        end else if (clk_en) begin
            if (!strap_done) begin
                cur_mode <= pin_sync ? mode_micro : mode_single;
            end else if (strobe_rise && pend_valid) begin
                // forced start relies on software keeping micro mode
                cur_mode <= pend_mode;
            end
        end
    end

    // wait bit, cleared at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_en_n <= mode_ctrl_rst[wait_bit];
        end else if (clk_en && wr_mode) begin
            wait_en_n <= bus_wdata[wait_bit];
        end
    end

    // software reset pulse; stretched so the reset tree sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swrst_cnt <= 4'h0;
        end else if (clk_en) begin
            // load on the first strobe cycle only, so a long write
            // cycle cannot stretch the pulse
            if (wr_mode && strobe_q && bus_wdata[swrst_bit]) begin
                swrst_cnt <= swrst_cycles;
            end else if (swrst_cnt != 4'h0) begin
                swrst_cnt <= swrst_cnt - 4'h1;
            end
        end
    end

    assign sw_reset_req = (swrst_cnt != 4'h0);
    assign active_mode  = cur_mode;

    // ------------------------------------------------------------------
    // internal memories
    // ------------------------------------------------------------------
    logic [7:0]        ram_mem [ram_bytes];
    logic [7:0]        ram_q;
    logic [ram_aw-1:0] ram_idx;
    logic              rom_on;
    logic              int_hit;

    assign ram_idx  = ram_aw'(bus_addr - ram_base);
    assign rom_on   = (cur_mode != mode_micro); // internal rom off in micro
    assign int_hit  = hit_ram || hit_sfr || (hit_rom && rom_on);
    assign rom_addr = bus_addr[rom_aw-1:0];

    // ram written on strobe regardless of any parallel external write
    always_ff @(posedge clk) begin
        if (clk_en && !bus_strobe_n && !bus_rd_wr_n && hit_ram) begin
            ram_mem[ram_idx] <= bus_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en) begin
            ram_q <= ram_mem[ram_idx];
        end
    end

    // ------------------------------------------------------------------
    // external access sequencer
    // ------------------------------------------------------------------
    ext_state_t ext_state;
    logic       ext_req;
    logic       ext_mode;
    logic [7:0] ext_q;

    assign ext_mode = (cur_mode != mode_single);
    // overlapping writes also go outside; overlapping reads stay internal
    assign ext_req  = ext_mode && !bus_strobe_n && !hit_mode_reg &&
                      (!int_hit || !bus_rd_wr_n);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_state <= ext_idle;
        end else if (clk_en) begin
            case (ext_state)
                ext_idle: begin
                    if (ext_req) ext_state <= ext_strobe;
                end
                ext_strobe: begin
                    // wait bit zero holds the strobe low three cycles instead of two
                    ext_state <= wait_en_n ? ext_release
                                           : ext_wait;
                end
                ext_wait:    ext_state <= ext_release;
                ext_release: begin
                    if (bus_strobe_n) ext_state <= ext_idle;
                end
                default:     ext_state <= ext_idle;
            endcase
        end
    end

    // external bus outputs registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_addr     <= 24'h000000;
            ext_wdata    <= 8'h00;
            ext_data_oe  <= 1'b0;
            ext_strobe_n <= 1'b1;
            ext_rd_wr_n  <= 1'b1;
            ext_q        <= 8'h00;
        end else if (clk_en) begin
            ext_strobe_n <= !(ext_req && (ext_state != ext_release));
            if (ext_req && ext_state == ext_idle) begin
                ext_addr    <= bus_addr;
                ext_wdata   <= bus_wdata;
                ext_rd_wr_n <= bus_rd_wr_n;
                ext_data_oe <= !bus_rd_wr_n;
            end else if (ext_state == ext_release || !ext_mode) begin
                ext_data_oe <= 1'b0;
                ext_rd_wr_n <= 1'b1;
            end
            if (ext_state != ext_idle && bus_rd_wr_n) ext_q <= ext_rdata;
        end
    end

    assign ext_bus_en = ext_mode;

    // internal reads never wait; in expansion modes overlapping writes wait for the external cycle
    assign bus_ready = !ext_req || (ext_state == ext_release);

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    logic [7:0] mode_rd;
    logic       rom_rd_q;
    logic       ram_rd_q;
    logic       reg_rd_q;

    // software reset bit is write only and reads zero
    assign mode_rd = {4'h0, 1'b0, wait_en_n, cur_mode};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_rd_q <= 1'b0;
            ram_rd_q <= 1'b0;
            reg_rd_q <= 1'b0;
        end else if (clk_en) begin
            rom_rd_q <= hit_rom && rom_on;
            ram_rd_q <= hit_ram;
            reg_rd_q <= hit_mode_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd_q)      bus_rdata <= mode_rd;
            else if (ram_rd_q) bus_rdata <= ram_q;
            else if (rom_rd_q) bus_rdata <= rom_data;
            else if (ext_mode) bus_rdata <= ext_q;
            else               bus_rdata <= 8'h00;
        end
    end

    // decode outputs
    assign sel_sfr    = hit_sfr;
    assign sel_ram    = hit_ram;
    assign sel_rom    = hit_rom && rom_on;
    assign sel_vector = hit_vec;

endmodule // mem_mode_ctrl

// *** testbench/mem_mode_props.sv ***
// assertion checker for the memory map and mode control block
module mem_mode_props
    import mem_mode_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // cpu side
    input wire logic [23:0] bus_addr,
    input wire logic        bus_strobe_n,
    input wire logic        bus_ready,
    // expansion bus and status
    input wire logic        ext_strobe_n,
    input wire logic        ext_data_oe,
    input wire logic        ext_bus_en,
    input wire logic        sel_ram,
    input wire logic        sel_rom,
    input wire logic        sel_vector,
    input wire logic [1:0]  active_mode,
    input wire logic        sw_reset_req
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // settle counter: keeps the strap capture out of the mode-change check
    logic [2:0] up;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end

    property p_ram;
        sel_ram == (bus_addr >= ram_base && bus_addr <= ram_last);
    endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_rom;
        sel_rom == (bus_addr >= rom_base && bus_addr <= rom_last
                    && active_mode != mode_micro);
    endproperty
    a_rom: assert property (p_rom) else $error("rom select wrong");
    property p_vec;
        sel_vector == (bus_addr >= vec_base && bus_addr <= vec_last);
    endproperty
    a_vec: assert property (p_vec) else $error("vector select wrong");
    // registered outputs may finish one cycle after leaving an expansion mode
    property p_quiet;
        active_mode == mode_single && $past(active_mode) == mode_single
            |-> ext_strobe_n && !ext_data_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus active");
    property p_bus_en;
        ext_bus_en == (active_mode != mode_single);
    endproperty
    a_bus_en: assert property (p_bus_en) else $error("bus enable");
    property p_nowait;
        active_mode == mode_single |-> bus_ready;
    endproperty
    a_nowait: assert property (p_nowait) else $error("stall");
    property p_legal;
        active_mode != mode_reserved;
    endproperty
    a_legal: assert property (p_legal) else $error("bad mode");
    property p_pins;
        up == 3'h7 && $changed(active_mode) |-> $past(bus_strobe_n)
            && (!$past(bus_strobe_n, 2) || !$past(bus_strobe_n, 3));
    endproperty
    a_pins: assert property (p_pins) else $error("mode early");
    property p_swrst;
        $rose(sw_reset_req) |-> sw_reset_req [*8] ##1 !sw_reset_req;
    endproperty
    a_swrst: assert property (p_swrst) else $error("reset pulse");
endmodule // mem_mode_props

bind mem_mode_ctrl mem_mode_props u_props (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_strobe_n(bus_strobe_n), .bus_ready(bus_ready),
    .ext_strobe_n(ext_strobe_n), .ext_data_oe(ext_data_oe),
    .ext_bus_en(ext_bus_en), .sel_ram(sel_ram), .sel_rom(sel_rom),
    .sel_vector(sel_vector), .active_mode(active_mode),
    .sw_reset_req(sw_reset_req));

// *** testbench/ext_mem_model.sv ***
// behavioural external memory on the expansion bus
module ext_mem_model (
    input  wire logic        clk,
    input  wire logic [23:0] ext_addr,
    input  wire logic [7:0]  ext_wdata,
    input  wire logic        ext_data_oe,
    input  wire logic        ext_strobe_n,
    input  wire logic        ext_rd_wr_n,
    output logic      [7:0]  ext_rdata,
    output logic      [23:0] last_addr,
    output logic      [7:0]  last_data,
    output int               n_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] held = 8'h00;
    logic       prev_n = 1'b1;
    initial n_wr = 0;
    // read data is an address pattern, so it also serves as the vector rom
    // when internal rom is off; a released bus shows the inverse of the last
    always_comb begin
        if (!ext_strobe_n && ext_rd_wr_n)
            ext_rdata = ext_addr[7:0] ^ 8'ha5;
        else
            ext_rdata = ~held;
    end
    // capture writes while the strobe is low, one count per strobe
    always @(posedge clk) begin
        if (!ext_strobe_n && !ext_rd_wr_n && ext_data_oe) begin
            last_addr <= ext_addr;
            last_data <= ext_wdata;
            if (prev_n) n_wr <= n_wr + 1;
        end
        if (!ext_strobe_n && ext_rd_wr_n) held <= ext_rdata;
        prev_n <= ext_strobe_n;
    end
endmodule // ext_mem_model

// *** testbench/memory_map_and_mode_control_test.sv ***
// self-checking bench for the memory map and mode control block
module memory_map_and_mode_control_test import mem_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, pin = 1'b0;
    logic        strb_n = 1'b1, rd_wr_n = 1'b1;
    logic [23:0] bus_addr = 24'h000000, ext_addr, last_addr;
    logic [7:0]  wdata = 8'h00, rdata, rom_data, ext_rdata, ext_wdata;
    logic [7:0]  last_data;
    logic [13:0] rom_addr;
    logic        ready, ext_oe, ext_strb_n, ext_rw_n, bus_en;
    logic        s_sfr, s_ram, s_rom, s_vec, swrst;
    logic [1:0]  mode;
    int          mismatches = 0, n_checks = 0, n_strb = 0, n_rst = 0, n_wr;

    mem_mode_ctrl dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .mode_select_pin(pin),
        .bus_addr(bus_addr), .bus_strobe_n(strb_n), .bus_rd_wr_n(rd_wr_n),
        .bus_wdata(wdata), .bus_rdata(rdata), .bus_ready(ready),
        .rom_addr(rom_addr), .rom_data(rom_data), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_data_oe(ext_oe), .ext_rdata(ext_rdata),
        .ext_strobe_n(ext_strb_n), .ext_rd_wr_n(ext_rw_n),
        .ext_bus_en(bus_en), .sel_sfr(s_sfr), .sel_ram(s_ram), .sel_rom(s_rom),
        .sel_vector(s_vec), .active_mode(mode), .sw_reset_req(swrst));
    ext_mem_model partner (
        .clk(clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_data_oe(ext_oe), .ext_strobe_n(ext_strb_n),
        .ext_rd_wr_n(ext_rw_n), .ext_rdata(ext_rdata),
        .last_addr(last_addr), .last_data(last_data), .n_wr(n_wr));

    // rom image is an address pattern so internal reads are recognisable
    assign rom_data = rom_addr[7:0] ^ 8'h3c;
    always #10 clk = ~clk;
    // strobe and reset-pulse lengths counted in the background
    always @(posedge clk) begin
        if (ext_strb_n === 1'b0) n_strb <= n_strb + 1;
        if (swrst === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one cpu cycle: held until ready is seen at a falling edge, then one more rising edge
    task automatic access(logic [23:0] a, logic rw, logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk) #2;
        bus_addr = a;
        rd_wr_n = rw;
        wdata = d;
        strb_n = 1'b0;
        repeat (2) @(posedge clk);
        for (int n = 0; n < 20; n++) begin
            @(negedge clk);
            if (ready === 1'b1) break;
        end
        check("bus_ready", ready, 1'b1);
        @(posedge clk) #1 q = rdata;
        #1 strb_n = 1'b1;
    endtask
    task automatic wr(logic [23:0] a, logic [7:0] d);
        logic [7:0] q;
        access(a, 1'b0, d, q);
    endtask
    task automatic rd(logic [23:0] a, output logic [7:0] q);
        access(a, 1'b1, 8'h00, q);
    endtask
    task automatic set_mode(logic [7:0] v);
        wr(mode_ctrl_addr, v);
        repeat (3) @(posedge clk);
        #2;
    endtask
    task automatic do_reset(logic p);
        rst_n = 1'b0;
        pin = p;
        repeat (16) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #2;
    endtask
    task automatic results();
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic t_reset();
        logic [7:0] q;
        check("mode", mode, mode_single);
        rd(mode_ctrl_addr, q);
        check("mode_reg", q & 8'h0f, mode_ctrl_rst & 8'h0f);
    endtask
    task automatic t_decode();
        logic [23:0] t [10] = '{24'h00005e, 24'h00007f, 24'h000080,
            24'h00027f, 24'h000280, 24'h00bfff, 24'h00c000, 24'h00ffd5,
            24'h00ffd6, 24'h01ffff};
        foreach (t[i]) begin
            @(posedge clk) #2;
            bus_addr = t[i];
            #1;
            check("sfr", s_sfr, t[i] <= sfr_last);
            check("ram", s_ram, t[i] >= ram_base && t[i] <= ram_last);
            check("rom", s_rom, t[i] >= rom_base && t[i] <= rom_last);
            check("vec", s_vec, t[i] >= vec_base && t[i] <= vec_last);
        end
    endtask
    task automatic t_modes();
        logic [7:0] q;
        logic [1:0] s [3] = '{mode_expand, mode_micro, mode_single};
        foreach (s[i]) begin
            set_mode({6'h01, s[i]});
            check("mode", mode, s[i]);
            check("bus_en", bus_en, s[i] != mode_single);
        end
        set_mode({6'h01, mode_reserved});
        check("mode", mode, mode_single);
        rd(mode_ctrl_addr, q);
        check("wait", q[wait_bit], 1'b1);
    endtask
    task automatic t_ext();
        logic [7:0] q;
        int w;
        for (int b = 0; b < 2; b++) begin
            set_mode({5'h00, b[0], mode_expand});
            n_strb = 0;
            w = n_wr;
            wr(24'h010040 + b, 8'h6c);
            check("strobe", n_strb, 3 - b);
            check("ext_wr", n_wr - w, 1);
            check("ext_addr", last_addr, 24'h010040 + b);
            check("ext_data", last_data, 8'h6c);
        end
        w = n_wr;
        wr(24'h000100, 8'h3a);
        check("ovl_wr", n_wr - w, 1);
        rd(24'h000100, q);
        check("ram_rd", q, 8'h3a);
        rd(24'h00c010, q);
        check("rom_rd", q, 8'h10 ^ 8'h3c);
        rd(24'h020033, q);
        check("ext_rd", q, 8'h33 ^ 8'ha5);
        // bank stays 0 and no bit set/clear is used
        set_mode(8'h00);
        n_strb = 0;
        wr(24'h000100, 8'h11);
        check("strobe", n_strb, 0);
    endtask
    task automatic t_swrst();
        logic [7:0] q;
        n_rst = 0;
        wr(mode_ctrl_addr, 8'h08);
        repeat (14) @(posedge clk);
        check("swrst", n_rst, swrst_cycles);
        rd(mode_ctrl_addr, q);
        check("swrst_bit", q[swrst_bit], 1'b0);
    endtask
    task automatic t_micro();
        logic [7:0] q;
        do_reset(1'b1);
        check("mode", mode, mode_micro);
        // mode bits are left alone after a forced start
        rd(24'h00ffd6, q);
        check("vector", q, 8'hd6 ^ 8'ha5);
        // a write while frozen must leave the wait bit at its reset value
        clk_en = 1'b0;
        wr(mode_ctrl_addr, {6'h01, mode_micro}); // keeps micro
        repeat (2) @(posedge clk);
        #2 clk_en = 1'b1;
        rd(mode_ctrl_addr, q);
        check("frozen", q, {6'h00, mode_micro});
        check("mode", mode, mode_micro);
    endtask

    initial begin
        do_reset(1'b0);
        t_reset();
        t_decode();
        t_modes();
        t_ext();
        t_swrst();
        t_micro();
        results();
    end
    // watchdog: the sequence needs well under ten thousand cycles
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule // memory_map_and_mode_control_test
